/* File: dco_loop_pkg.sv */
`default_nettype none
package dco_loop_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses on the APB)
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] STATE_OFS     = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS  = 8'h0c;
	localparam logic [7:0] TRIM_OFS      = 8'h10;
	// Control fields
	localparam int         CTRL_MON_BIT  = 8;
	localparam int         CTRL_ICG_BIT  = 9;
	localparam int         CTRL_STOP_BIT = 10;
	// Reset values
	localparam logic [6:0] MULT_RST      = 7'h01;
	localparam logic [7:0] TRIM_RST      = 8'h80;
	localparam logic [7:0] STAGE_RST     = 8'h00;
	localparam logic [3:0] DIV_RST       = 4'h0;
	// Interrupt event bits
	localparam int         EV_STABLE     = 0;
	localparam int         EV_FAULT      = 1;
	localparam int         EV_RESTART    = 2;
	localparam int         EV_W          = 3;
	// ---------------------------------------------------------------
	// Oscillator and loop constants
	// ---------------------------------------------------------------
	localparam logic [4:0] RING_MIN      = 5'h11;
	localparam logic [2:0] UPPER_TOP     = 3'h7;
	localparam logic [3:0] DIV_MAX       = 4'h9;
	localparam logic [7:0] STEP_COARSE   = 8'h20;
	localparam logic [7:0] STEP_MEDIUM   = 8'h08;
	localparam logic [7:0] STEP_FINE     = 8'h01;
	localparam logic [1:0] CORR_BASE_LAST = 2'h3;
	// Error bands as ratios: 15 % = 3/20, 5 % = 1/20
	localparam logic [4:0] BAND_DEN      = 5'h14;
	localparam logic [1:0] COARSE_NUM    = 2'h3;
	localparam logic [1:0] MEDIUM_NUM    = 2'h1;

	typedef enum logic [1:0] {BAND_FINE, BAND_MEDIUM, BAND_COARSE} band_t;
endpackage
`default_nettype wire

/* File: stage_stepper.sv */
`timescale 1ns/100ps
`default_nettype none
module stage_stepper
	import dco_loop_pkg::*;
(
	input  wire logic [7:0] stage,
	input  wire logic [3:0] div,
	input  wire logic [7:0] step,
	input  wire logic       up,
	output logic      [7:0] stage_out,
	output logic      [3:0] div_out
);
	logic [8:0] sum;
	logic [3:0] eff_div;

	// ---------------------------------------------------------------
	// Step with carry or borrow into the divider
	// ---------------------------------------------------------------
	// Codes above the top divider act as the top one
	assign eff_div = (div > DIV_MAX) ? DIV_MAX : div;

	// Only a carry or borrow moves the divider, never the step itself
	always_comb begin
		sum = up ? ({1'b0, stage} + {1'b0, step})
			: ({1'b0, stage} - {1'b0, step});
		stage_out = sum[7:0];
		div_out = eff_div;
		if (sum[8]) begin
			if (up) begin
				if (eff_div == DIV_MAX) begin
					stage_out = 8'hff;
				end else begin
					div_out = eff_div + 4'h1;
				end
			end else begin
				if (eff_div == 4'h0) begin
					stage_out = 8'h00;
				end else begin
					div_out = eff_div - 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: fine_dither.sv */
`timescale 1ns/100ps
`default_nettype none
module fine_dither
	import dco_loop_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       internal_clock_tick,
	input  wire logic [7:0] stage,
	output logic      [4:0] ring_stages,
	output logic            halve_period
);
	typedef struct packed {
		logic [4:0] cnt;
		logic [4:0] ring;
		logic       halve;
	} dith_t;
	dith_t st_r, st_nxt;
	logic  long_pt;
	logic [4:0] nominal;

	// ---------------------------------------------------------------
	// Ring point selection
	// ---------------------------------------------------------------
	// Long point for k of every 32 internal clock cycles
	assign long_pt = st_r.cnt < stage[4:0];
	assign nominal = RING_MIN + {1'b0, stage[7:5], 1'b0};

	always_comb begin
		st_nxt = st_r;
		if (internal_clock_tick) begin
			st_nxt.cnt = st_r.cnt + 5'h01;
		end
		st_nxt.halve = 1'b0;
		st_nxt.ring = nominal;
		if (long_pt) begin
			if (stage[7:5] == UPPER_TOP) begin
				// Nothing longer than 31 exists: 17 halved gives 34
				st_nxt.ring = RING_MIN;
				st_nxt.halve = 1'b1;
			end else begin
				st_nxt.ring = nominal + 5'h02;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{cnt: 5'h00, ring: RING_MIN, halve: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ring_stages = st_r.ring;
	assign halve_period = st_r.halve;

	chk_alt_point: assert property (@(posedge pclk) disable iff (!presetn)
		(stage[7:5] == UPPER_TOP && long_pt) |=> (ring_stages == RING_MIN
		&& halve_period))
		else $error("top field long point is not 17 halved");
	chk_ring_range: assert property (@(posedge pclk) disable iff (!presetn)
		!halve_period |-> (ring_stages >= RING_MIN && ring_stages <= 5'h1f
		&& ring_stages[0]))
		else $error("ring stage count outside 17..31 odd");
endmodule
`default_nettype wire

/* File: dco_loop_filter.sv */
// Summary of operation
// - Upper three bits pick 17..31 stages
// - Lower five bits: k of 32 longer
// - Top field alternate is 17 halved
// - Lowest bit is the smallest step
// - Above 15 percent step bit five
// - Regulate to multiplier times base clock
// - Monitor enable refused until stable again
// - Multiplier write never blocked by hardware
// - Restart settling on reset, N, trim, enable
// - One correction per four base periods
// - Coarse band halves or doubles in eight
// - Middle band steps about two percent
// - Stable flag set at or below 5 percent
// - Fine band minimum steps keep correcting
// - Divider moves only on carry or borrow
// - Divider saturates at nine
`timescale 1ns/100ps
`default_nettype none
module dco_loop_filter
	import dco_loop_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        base_clock_tick,
	input  wire logic        internal_clock_tick,
	input  wire logic        monitor_fault_flag,
	output logic      [7:0]  oscillator_stage_control,
	output logic      [3:0]  oscillator_divider_select,
	output logic      [4:0]  ring_stages,
	output logic             halve_period,
	output logic             internal_clock_stable_flag,
	output logic             monitor_enable,
	output logic             irq
);
	typedef struct packed {
		logic [7:0]      stage;
		logic [3:0]      div;
		logic            stable;
		band_t           band;
		logic [1:0]      base_cnt;
		logic [15:0]     ick_cnt;
		logic [6:0]      mult;
		logic            mon_en;
		logic            icg_en;
		logic            stop;
		logic [7:0]      trim;
		logic [EV_W-1:0] irq_stat;
		logic [EV_W-1:0] irq_mask;
		logic [31:0]     rdata;
	} loop_t;
	loop_t st_r, st_nxt;

	logic        wr_acc;
	logic        rd_setup;
	logic        mapped;
	logic [8:0]  target;
	logic        too_fast;
	logic [15:0] diff;
	logic [20:0] diff_scaled;
	logic [10:0] coarse_lim;
	logic [10:0] medium_lim;
	band_t       band_now;
	logic        corr;
	logic [7:0]  step;
	logic [7:0]  stage_step;
	logic [3:0]  div_step;
	logic        restart;
	logic [EV_W-1:0] events;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	// Zero wait states: every access completes in its first access cycle
	assign mapped = (paddr == CTRL_OFS) || (paddr == STATE_OFS)
		|| (paddr == IRQ_STAT_OFS) || (paddr == IRQ_MASK_OFS)
		|| (paddr == TRIM_OFS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_acc = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;

	// ---------------------------------------------------------------
	// Frequency error measurement
	// ---------------------------------------------------------------
	// Four base periods should hold exactly 4*N internal clock cycles
	assign target = {st_r.mult, 2'b00};
	assign too_fast = st_r.ick_cnt > {7'h00, target};
	assign diff = too_fast ? (st_r.ick_cnt - {7'h00, target})
		: ({7'h00, target} - st_r.ick_cnt);
	// Ratios kept in integers to avoid a divider: diff/target vs 3/20
	assign diff_scaled = diff * BAND_DEN;
	assign coarse_lim = target * COARSE_NUM;
	assign medium_lim = target * MEDIUM_NUM;

	always_comb begin
		if (diff_scaled > {10'h0, coarse_lim}) begin
			band_now = BAND_COARSE;
		end else if (diff_scaled > {10'h0, medium_lim}) begin
			band_now = BAND_MEDIUM;
		end else begin
			band_now = BAND_FINE;
		end
	end

	// A correction closes every fourth base clock period while icg_en is set and stop is clear
	assign corr = base_clock_tick && (st_r.base_cnt == CORR_BASE_LAST)
		&& st_r.icg_en && !st_r.stop;

	// Step size from the error band
	always_comb begin
		unique case (band_now)
			BAND_COARSE: step = STEP_COARSE;
			BAND_MEDIUM: step = STEP_MEDIUM;
			BAND_FINE:   step = (diff == 16'h0000) ? 8'h00 : STEP_FINE;
		endcase
	end

	// Too fast means the period is short, so lengthen it
	stage_stepper u_stepper (
		.stage     (st_r.stage),
		.div       (st_r.div),
		.step      (step),
		.up        (too_fast),
		.stage_out (stage_step),
		.div_out   (div_step)
	);

	// ---------------------------------------------------------------
	// Settling restart detection
	// ---------------------------------------------------------------
	always_comb begin
		restart = 1'b0;
		if (wr_acc && paddr == CTRL_OFS) begin
			if (pwdata[6:0] != st_r.mult) begin
				restart = 1'b1;
			end
			if (pwdata[CTRL_ICG_BIT] && !st_r.icg_en) begin
				restart = 1'b1;
			end
			if (!pwdata[CTRL_STOP_BIT] && st_r.stop) begin
				restart = 1'b1;
			end
		end
		if (wr_acc && paddr == TRIM_OFS && pwdata[7:0] != st_r.trim) begin
			restart = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		events = '0;
		// Measurement window
		if (internal_clock_tick && st_r.ick_cnt != 16'hffff) begin
			st_nxt.ick_cnt = st_r.ick_cnt + 16'h0001;
		end
		if (base_clock_tick) begin
			st_nxt.base_cnt = st_r.base_cnt + 2'h1;
		end
		if (corr) begin
			st_nxt.stage = stage_step;
			st_nxt.div = div_step;
			st_nxt.band = band_now;
			st_nxt.ick_cnt = internal_clock_tick ? 16'h0001 : 16'h0000;
			// Loop keeps correcting after the flag is up
			if (band_now == BAND_FINE) begin
				st_nxt.stable = 1'b1;
				events[EV_STABLE] = !st_r.stable;
			end
		end
		if (monitor_fault_flag) begin
			events[EV_FAULT] = 1'b1;
		end
		// Register writes
		if (wr_acc) begin
			unique case (paddr)
				CTRL_OFS: begin
					// No interlock: a new multiplier applies at once
					st_nxt.mult = pwdata[6:0];
					st_nxt.icg_en = pwdata[CTRL_ICG_BIT];
					st_nxt.stop = pwdata[CTRL_STOP_BIT];
					// Monitor may only come on with a stable clock
					if (!pwdata[CTRL_MON_BIT]) begin
						st_nxt.mon_en = 1'b0;
					end else if (st_r.stable && !restart) begin
						st_nxt.mon_en = 1'b1;
					end
				end
				IRQ_STAT_OFS: begin
					st_nxt.irq_stat = st_r.irq_stat & ~pwdata[EV_W-1:0];
				end
				IRQ_MASK_OFS: begin
					st_nxt.irq_mask = pwdata[EV_W-1:0];
				end
				TRIM_OFS: begin
					st_nxt.trim = pwdata[7:0];
				end
				default: begin
				end
			endcase
		end
		if (restart) begin
			st_nxt.stable = 1'b0;
			st_nxt.band = BAND_COARSE;
			st_nxt.base_cnt = 2'h0;
			st_nxt.ick_cnt = 16'h0000;
			events[EV_RESTART] = 1'b1;
		end
		// Sticky bits: a new event beats a clear in the same cycle
		st_nxt.irq_stat = st_nxt.irq_stat | events;
		// Read data captured in the setup cycle
		if (rd_setup) begin
			unique case (paddr)
				CTRL_OFS: st_nxt.rdata = {21'h0, st_r.stop,
					st_r.icg_en, st_r.mon_en, 1'b0, st_r.mult};
				STATE_OFS: st_nxt.rdata = {17'h0, st_r.band,
					st_r.stable, st_r.div, st_r.stage};
				IRQ_STAT_OFS: st_nxt.rdata = {29'h0, st_r.irq_stat};
				IRQ_MASK_OFS: st_nxt.rdata = {29'h0, st_r.irq_mask};
				TRIM_OFS: st_nxt.rdata = {24'h000000, st_r.trim};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	// Reset is itself a settling start: flag clear, counters empty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{stage: STAGE_RST, div: DIV_RST, stable: 1'b0,
				band: BAND_COARSE, base_cnt: 2'h0, ick_cnt: 16'h0000,
				mult: MULT_RST, mon_en: 1'b0, icg_en: 1'b1, stop: 1'b0,
				trim: TRIM_RST, irq_stat: '0, irq_mask: '0,
				rdata: 32'h00000000};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Oscillator fine adjust and outputs
	// ---------------------------------------------------------------
	fine_dither u_dither (
		.pclk                (pclk),
		.presetn             (presetn),
		.internal_clock_tick (internal_clock_tick),
		.stage               (st_r.stage),
		.ring_stages         (ring_stages),
		.halve_period        (halve_period)
	);

	assign prdata = st_r.rdata;
	assign oscillator_stage_control = st_r.stage;
	assign oscillator_divider_select = st_r.div;
	assign internal_clock_stable_flag = st_r.stable;
	assign monitor_enable = st_r.mon_en;
	assign irq = |(st_r.irq_stat & st_r.irq_mask);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	chk_corr_pacing: assert property (@(posedge pclk) disable iff (!presetn)
		corr |-> (base_clock_tick && st_r.base_cnt == CORR_BASE_LAST))
		else $error("correction outside fourth base period");
	chk_fine_step: assert property (@(posedge pclk) disable iff (!presetn)
		(corr && band_now == BAND_FINE && diff != 16'h0000 && too_fast
		&& st_r.stage != 8'hff) |=> (st_r.stage == $past(st_r.stage) + 8'h01))
		else $error("fine correction is not one stage unit");
	chk_coarse_step: assert property (@(posedge pclk) disable iff (!presetn)
		(corr && band_now == BAND_COARSE && !too_fast
		&& st_r.stage >= STEP_COARSE)
		|=> (st_r.stage == $past(st_r.stage) - STEP_COARSE))
		else $error("coarse correction is not bit five");
	chk_stable_set: assert property (@(posedge pclk) disable iff (!presetn)
		(corr && band_now == BAND_FINE && !restart) |=> st_r.stable)
		else $error("stable flag missing after fine band reached");
	chk_restart_clr: assert property (@(posedge pclk) disable iff (!presetn)
		restart |=> (!st_r.stable && st_r.ick_cnt == 16'h0000))
		else $error("settling restart did not clear the loop");
	chk_mon_refused: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st_r.mon_en) |-> $past(st_r.stable))
		else $error("monitor enabled without stable clock");
	chk_div_carry: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r.div != $past(st_r.div)) |-> $past(corr))
		else $error("divider moved without a correction");
	chk_div_sat: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.div <= DIV_MAX)
		else $error("divider beyond divide by 512");
	chk_mult_free: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == CTRL_OFS) |=> (st_r.mult == $past(pwdata[6:0])))
		else $error("multiplier write was blocked");
endmodule
`default_nettype wire

/* File: dco_loop_filter_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module dco_loop_filter_tb_top
	import dco_loop_pkg::*;
;
	// ------------------------------------------------------------
	// Bench signals and the unit
	// ------------------------------------------------------------
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        base_clock_tick;
	logic        internal_clock_tick;
	logic        monitor_fault_flag;
	logic [7:0]  stage;
	logic [3:0]  div;
	logic [4:0]  ring;
	logic        halve;
	logic        stable;
	logic        mon_en;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	int          fail_count;
	int          tests_run;

	dco_loop_filter uut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.base_clock_tick(base_clock_tick),
		.internal_clock_tick(internal_clock_tick),
		.monitor_fault_flag(monitor_fault_flag),
		.oscillator_stage_control(stage),
		.oscillator_divider_select(div),
		.ring_stages(ring),
		.halve_period(halve),
		.internal_clock_stable_flag(stable),
		.monitor_enable(mon_en),
		.irq(irq)
	);

	// 100 MHz bus clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic summarize();
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
			input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; the wait on pready is bounded
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
		if (pready !== 1'b1) begin
			fail_count++;
			summarize();
		end
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
			input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge pclk);
			internal_clock_tick <= 1'b1;
		end
		@(posedge pclk);
		internal_clock_tick <= 1'b0;
	endtask

	// One window: n internal ticks, then four base ticks
	task automatic corr(input int n, input logic [7:0] exp, input bit cs);
		logic [7:0] was;
		was = stage;
		ticks(n);
		repeat (3) begin
			@(posedge pclk);
			base_clock_tick <= 1'b1;
			@(posedge pclk);
			base_clock_tick <= 1'b0;
		end
		@(posedge pclk);
		chk("stage early", 32'(stage), 32'(was));
		base_clock_tick <= 1'b1;
		@(posedge pclk);
		base_clock_tick <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		if (cs) chk("stage", 32'(stage), 32'(exp));
	endtask

	// Counts long-point cycles over a full 32-tick dither period
	task automatic dith(input logic [4:0] r, input logic h, input int k);
		int c;
		c = 0;
		repeat (2) begin
			@(posedge pclk);
			internal_clock_tick <= 1'b1;
		end
		repeat (32) begin
			@(posedge pclk);
			#1;
			if (ring === r && halve === h) c++;
		end
		@(posedge pclk);
		internal_clock_tick <= 1'b0;
		chk("long cycles", 32'(c), 32'(k));
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk("ring rst", 32'(ring), 32'(RING_MIN));
		rchk("ctrl rst", CTRL_OFS, 32'h0000_0201);
		rchk("state rst", STATE_OFS, 32'h0000_4000);
		rchk("trim rst", TRIM_OFS, 32'h0000_0080);
		rchk("mask rst", IRQ_MASK_OFS, 32'h0);
		apb(1'b1, STATE_OFS, 32'hffff_ffff);
		rchk("state ro", STATE_OFS, 32'h0000_4000);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped err", 32'(er), 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h0000_0301);
		chk("mon refused", 32'(mon_en), 32'h0);
	endtask

	// Multiplier 10: window target is 40 ticks
	task automatic t_settle();
		apb(1'b1, CTRL_OFS, 32'h0000_020a);
		corr(30, 8'h00, 1'b1);
		chk("div borrow", 32'(div), 32'h0);
		corr(50, 8'h20, 1'b1);
		chk("ring 19", 32'(ring), 32'd19);
		corr(45, 8'h28, 1'b1);
		corr(41, 8'h29, 1'b1);
		chk("stable", 32'(stable), 32'h1);
		corr(40, 8'h29, 1'b1);
		rchk("state", STATE_OFS, 32'h0000_1029);
		dith(5'd21, 1'b0, 9);
	endtask

	task automatic t_irq();
		rchk("stat", IRQ_STAT_OFS, 32'h5);
		chk("irq masked", 32'(irq), 32'h0);
		apb(1'b1, IRQ_MASK_OFS, 32'h1);
		chk("irq on", 32'(irq), 32'h1);
		apb(1'b1, IRQ_STAT_OFS, 32'h1);
		chk("irq cleared", 32'(irq), 32'h0);
		@(posedge pclk);
		monitor_fault_flag <= 1'b1;
		@(posedge pclk);
		monitor_fault_flag <= 1'b0;
		rchk("stat fault", IRQ_STAT_OFS, 32'h6);
		apb(1'b1, IRQ_MASK_OFS, 32'h2);
		chk("irq fault", 32'(irq), 32'h1);
		apb(1'b1, IRQ_STAT_OFS, 32'h6);
		chk("irq fault clr", 32'(irq), 32'h0);
		apb(1'b1, CTRL_OFS, 32'h0000_030a);
		chk("mon on", 32'(mon_en), 32'h1);
	endtask

	// Multiplier 20: window target is 80 ticks
	task automatic t_top();
		apb(1'b1, CTRL_OFS, 32'h0000_020a);
		chk("mon off", 32'(mon_en), 32'h0);
		apb(1'b1, CTRL_OFS, 32'h0000_0214);
		chk("stable n", 32'(stable), 32'h0);
		rchk("ctrl n", CTRL_OFS, 32'h0000_0214);
		apb(1'b1, IRQ_STAT_OFS, 32'h7);
		apb(1'b1, TRIM_OFS, 32'h0000_0081);
		rchk("stat trim", IRQ_STAT_OFS, 32'h4);
		for (int i = 1; i <= 6; i++) begin
			corr(100, 8'(41 + 32 * i), 1'b1);
		end
		chk("stable coarse", 32'(stable), 32'h0);
		dith(5'd17, 1'b1, 9);
		corr(150, 8'h00, 1'b0);
		chk("div carry", 32'(div), 32'h1);
		apb(1'b1, CTRL_OFS, 32'h0000_0014);
		corr(100, stage, 1'b1);
		apb(1'b1, IRQ_STAT_OFS, 32'h7);
		apb(1'b1, CTRL_OFS, 32'h0000_0214);
		rchk("stat icg", IRQ_STAT_OFS, 32'h4);
		chk("stable icg", 32'(stable), 32'h0);
	endtask

	// Reset for eight cycles, then the scenarios in turn
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		base_clock_tick = 1'b0;
		internal_clock_tick = 1'b0;
		monitor_fault_flag = 1'b0;
		fail_count = 0;
		tests_run = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		t_reset();
		t_settle();
		t_irq();
		t_top();
		summarize();
	end
endmodule
`default_nettype wire
